// ---- rtl/stpw_regs.vh ----
// register offsets, field positions and reset values of the sawtooth pwm
`ifndef STPW_REGS_VH
`define STPW_REGS_VH
// byte offsets on apb
`define STPW_CTRL0_OFF 12'h000
`define STPW_CTRL1_OFF 12'h004
`define STPW_LVL0_OFF 12'h008
`define STPW_LVL1_OFF 12'h00c
`define STPW_DT_OFF 12'h010
`define STPW_IRQDIV_OFF 12'h014
`define STPW_SPC_OFF 12'h018
`define STPW_PERIOD_OFF 12'h01c
`define STPW_PW_U_OFF 12'h020
`define STPW_PW_V_OFF 12'h024
`define STPW_PW_W_OFF 12'h028
`define STPW_ALT_U_OFF 12'h02c
`define STPW_ALT_V_OFF 12'h030
`define STPW_ALT_W_OFF 12'h034
`define STPW_RUN_OFF 12'h038
`define STPW_STAT_OFF 12'h03c
// control 0 fields
`define STPW_C0_FUNC_EN 2
`define STPW_C0_OUT_EN 3
`define STPW_C0_SIMUL_SEL 4
`define STPW_C0_SIMUL_FLAG 5
`define STPW_C0_MOD_SEL 6
`define STPW_C0_SW_TRIG 7
// control 1 fields
`define STPW_C1_HALF_FLAG 3
`define STPW_C1_ACT_HIGH 4
`define STPW_C1_DT_DIS 5
// special control fields
`define STPW_SPC_RELOAD_SEL 0
`define STPW_SPC_CUTOFF_EN 1
// run register fields: u, v, w, carrier
`define STPW_RUN_CARRIER 3
// status fields
`define STPW_ST_IRQ 0
// reset values
`define STPW_CTRL0_RST 8'h00
`define STPW_CTRL1_RST 8'h00
`define STPW_LVL_RST 6'h00
`define STPW_DT_RST 8'h00
`define STPW_IRQDIV_RST 4'h1
`define STPW_PERIOD_RST 16'hffff
`define STPW_PW_RST 16'h0001
// dead-time slow clock divider step, giving a slow tick every fourth clock
`define STPW_DT_SLOW_DIV 2'h1
`endif

// ---- rtl/stpw_top.v ----
// sawtooth three-phase pwm timer with apb register access
// Functional notes
// - carrier period is m+1 count cycles, m from 0000h to ffffh
// - each phase width comes from its 16-bit pulse width n, 1 to ffffh
// - pwm reference cycle is one carrier period, not two
// - carrier reloads at each underflow; reload select must stay zero
// - phase timers count primary width each carrier underflow; alternate unused
// - each carrier underflow moves level buffer 0 into the phase signals and level buffer 1 into the shift register
// - carrier interrupt every nth underflow; timing select bits ignored
// - dead-time timer starts on transfer trigger and pulse falling edges
// - level buffers hold six output bits, five to zero; buffer 1 feeds shifter
// - simultaneous conduction flag plus enable/disable select bit
// - dead-time enable, clock select and trigger select bits exist
// - carrier register is 16 bits and sets the full period
// - phase width registers are 16 bits setting one-shot width
// - forced cutoff select kills outputs; upper bits must stay zero
// - with dead time, output going inactive follows; going active waits for dead time
// - software trigger bit makes a transfer trigger
`timescale 1ns/100ps
`include "stpw_regs.vh"
module stpw_top
(
    // clock and reset
    input wire clk_in,
    input wire sys_rst_in,
    // count source enable
    input wire count_en_in,
    // apb slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    // phase outputs u, u_n, v, v_n, w, w_n
    output reg [5:0] pwm_out,
    output reg [5:0] pwm_oe_out,
    // carrier interrupt request
    output reg carrier_irq_out
);

    // ********************************************************
    // registers
    // ********************************************************
    reg [7:0] ctrl0_reg;
    reg [7:0] ctrl1_reg;
    reg [5:0] lvl0_reg;
    reg [5:0] lvl1_reg;
    reg [7:0] dt_reg;
    reg [3:0] irqdiv_reg;
    reg [7:0] spc_reg;
    reg [15:0] period_reg;
    reg [15:0] pw_reg [0:2];
    reg [15:0] alt_reg [0:2];
    reg [3:0] run_reg;
    reg simul_flag_reg;
    reg irq_flag_reg;
    reg sw_trig_reg;

    // ********************************************************
    // counters and shift state
    // ********************************************************
    reg [15:0] carrier_cnt_reg;
    reg [15:0] phase_cnt_reg [0:2];
    reg [2:0] pulse_reg;
    reg [5:0] shift_reg;
    reg [5:0] phase_sig_reg;
    reg [3:0] irq_cnt_reg;
    reg [7:0] dt_cnt_reg;
    reg [1:0] dt_div_reg;

    wire apb_wr;
    wire apb_rd;
    wire carrier_run;
    wire underflow;
    wire transfer;
    wire [2:0] pulse_fall;
    wire dt_tick;
    wire dt_busy;
    wire dt_start;
    wire overlap;
    wire cutoff;
    reg addr_ok;
    reg [31:0] rd_mux;
    integer i;
    integer j;
    integer b;

    assign apb_wr = psel_in & penable_in & pwrite_in;
    assign apb_rd = psel_in & penable_in & ~pwrite_in;
    assign carrier_run = run_reg[`STPW_RUN_CARRIER] &
        ctrl0_reg[`STPW_C0_FUNC_EN];
    // carrier reload always on underflow in this mode
    assign underflow = carrier_run & count_en_in &
        (carrier_cnt_reg == 16'h0000);
    // transfer trigger from underflow or software bit
    assign transfer = underflow | sw_trig_reg;
    assign cutoff = spc_reg[`STPW_SPC_CUTOFF_EN];
    assign dt_tick = ctrl1_reg[2] ? (dt_div_reg == 2'h0) : 1'b1;

    // ********************************************************
    // apb decode
    // ********************************************************
    always @*
    begin
        addr_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr_in)
            `STPW_CTRL0_OFF: rd_mux = {24'h0, ctrl0_reg[7:6],
                simul_flag_reg, ctrl0_reg[4:0]};
            `STPW_CTRL1_OFF: rd_mux = {24'h0, ctrl1_reg[7:4], 1'b0,
                ctrl1_reg[2:0]};
            `STPW_LVL0_OFF: rd_mux = {26'h0, lvl0_reg};
            `STPW_LVL1_OFF: rd_mux = {26'h0, lvl1_reg};
            `STPW_DT_OFF: rd_mux = {24'h0, dt_reg};
            `STPW_IRQDIV_OFF: rd_mux = {28'h0, irqdiv_reg};
            `STPW_SPC_OFF: rd_mux = {24'h0, spc_reg};
            `STPW_PERIOD_OFF: rd_mux = {16'h0, carrier_cnt_reg};
            `STPW_PW_U_OFF: rd_mux = {16'h0, pw_reg[0]};
            `STPW_PW_V_OFF: rd_mux = {16'h0, pw_reg[1]};
            `STPW_PW_W_OFF: rd_mux = {16'h0, pw_reg[2]};
            `STPW_ALT_U_OFF: rd_mux = {16'h0, alt_reg[0]};
            `STPW_ALT_V_OFF: rd_mux = {16'h0, alt_reg[1]};
            `STPW_ALT_W_OFF: rd_mux = {16'h0, alt_reg[2]};
            `STPW_RUN_OFF: rd_mux = {28'h0, run_reg};
            `STPW_STAT_OFF: rd_mux = {24'h0, shift_reg, 1'b0,
                irq_flag_reg};
            default: addr_ok = 1'b0;
        endcase
    end

    always @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end
        else
        begin
            pready_out <= psel_in & ~penable_in;
            pslverr_out <= psel_in & ~penable_in & ~addr_ok;
            prdata_out <= (psel_in & ~penable_in & ~pwrite_in) ?
                rd_mux : 32'h0000_0000;
        end
    end

    // ********************************************************
    // register writes
    // ********************************************************
    always @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            ctrl0_reg <= `STPW_CTRL0_RST;
            ctrl1_reg <= `STPW_CTRL1_RST;
            lvl0_reg <= `STPW_LVL_RST;
            lvl1_reg <= `STPW_LVL_RST;
            dt_reg <= `STPW_DT_RST;
            irqdiv_reg <= `STPW_IRQDIV_RST;
            spc_reg <= 8'h00;
            period_reg <= `STPW_PERIOD_RST;
            run_reg <= 4'h0;
            sw_trig_reg <= 1'b0;
            for (i = 0; i < 3; i = i + 1)
            begin
                pw_reg[i] <= `STPW_PW_RST;
                alt_reg[i] <= `STPW_PW_RST;
            end
        end
        else
        begin
            sw_trig_reg <= apb_wr & pready_out &
                (paddr_in == `STPW_CTRL0_OFF) &
                pwdata_in[`STPW_C0_SW_TRIG];
            if (apb_wr & pready_out)
            begin
                case (paddr_in)
                    `STPW_CTRL0_OFF: ctrl0_reg <= {1'b0, pwdata_in[6:0]};
                    `STPW_CTRL1_OFF: ctrl1_reg <= {1'b0, pwdata_in[6:0]};
                    `STPW_LVL0_OFF: lvl0_reg <= pwdata_in[5:0];
                    `STPW_LVL1_OFF: lvl1_reg <= pwdata_in[5:0];
                    `STPW_DT_OFF: dt_reg <= pwdata_in[7:0];
                    `STPW_IRQDIV_OFF: irqdiv_reg <= pwdata_in[3:0];
                    `STPW_SPC_OFF: spc_reg <= pwdata_in[7:0];
                    `STPW_PERIOD_OFF: period_reg <= pwdata_in[15:0];
                    `STPW_PW_U_OFF: pw_reg[0] <= pwdata_in[15:0];
                    `STPW_PW_V_OFF: pw_reg[1] <= pwdata_in[15:0];
                    `STPW_PW_W_OFF: pw_reg[2] <= pwdata_in[15:0];
                    `STPW_ALT_U_OFF: alt_reg[0] <= pwdata_in[15:0];
                    `STPW_ALT_V_OFF: alt_reg[1] <= pwdata_in[15:0];
                    `STPW_ALT_W_OFF: alt_reg[2] <= pwdata_in[15:0];
                    `STPW_RUN_OFF: run_reg <= pwdata_in[3:0];
                    default: ;
                endcase
            end
        end
    end

    // ********************************************************
    // carrier timer and interrupt divider
    // ********************************************************
    always @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            carrier_cnt_reg <= `STPW_PERIOD_RST;
            irq_cnt_reg <= 4'h0;
            irq_flag_reg <= 1'b0;
            carrier_irq_out <= 1'b0;
        end
        else
        begin
            carrier_irq_out <= 1'b0;
            if (!carrier_run)
                carrier_cnt_reg <= period_reg;
            else if (underflow)
                carrier_cnt_reg <= period_reg;
            else if (count_en_in)
                carrier_cnt_reg <= carrier_cnt_reg - 16'h0001;
            // selection bits 1:0 of control 0 are not looked at
            if (underflow)
            begin
                if (irq_cnt_reg + 4'h1 >= irqdiv_reg)
                begin
                    irq_cnt_reg <= 4'h0;
                    carrier_irq_out <= 1'b1;
                    irq_flag_reg <= 1'b1;
                end
                else
                    irq_cnt_reg <= irq_cnt_reg + 4'h1;
            end
            else if (apb_wr & pready_out & (paddr_in == `STPW_STAT_OFF) &
                pwdata_in[`STPW_ST_IRQ])
                irq_flag_reg <= 1'b0;
        end
    end

    // ********************************************************
    // phase one-shot timers
    // ********************************************************
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : phase_gen
            assign pulse_fall[g] = pulse_reg[g] & count_en_in &
                (phase_cnt_reg[g] == 16'h0001);
            always @(posedge clk_in)
            begin
                if (sys_rst_in)
                begin
                    phase_cnt_reg[g] <= 16'h0000;
                    pulse_reg[g] <= 1'b0;
                end
                else if (!run_reg[g])
                begin
                    phase_cnt_reg[g] <= 16'h0000;
                    pulse_reg[g] <= 1'b0;
                end
                else if (underflow)
                begin
                    // primary width only, alternate never used
                    phase_cnt_reg[g] <= pw_reg[g];
                    pulse_reg[g] <= 1'b1;
                end
                else if (pulse_fall[g])
                begin
                    phase_cnt_reg[g] <= 16'h0000;
                    pulse_reg[g] <= 1'b0;
                end
                else if (pulse_reg[g] & count_en_in)
                    phase_cnt_reg[g] <= phase_cnt_reg[g] - 16'h0001;
            end
        end
    endgenerate

    // ********************************************************
    // output shifter, dead time and pins
    // ********************************************************
    assign dt_busy = (dt_cnt_reg != 8'h00);
    // restart on transfer or, unless masked, on any pulse end
    assign dt_start = (transfer | ((|pulse_fall) & ~ctrl1_reg[6])) &
        ~ctrl1_reg[`STPW_C1_DT_DIS];

    // ********************************************************
    // internal phase signals and dead-time timer
    // ********************************************************
    always @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            shift_reg <= 6'h00;
            phase_sig_reg <= 6'h00;
            dt_cnt_reg <= 8'h00;
            dt_div_reg <= 2'h0;
        end
        else
        begin
            dt_div_reg <= dt_div_reg + `STPW_DT_SLOW_DIV;
            if (transfer)
                shift_reg <= lvl1_reg;
            // each phase pair takes its second level at its own pulse end
            for (j = 0; j < 3; j = j + 1)
            begin
                if (transfer)
                begin
                    phase_sig_reg[2*j] <= lvl0_reg[2*j];
                    phase_sig_reg[2*j+1] <= lvl0_reg[2*j+1];
                end
                else if (pulse_fall[j])
                begin
                    phase_sig_reg[2*j] <= shift_reg[2*j];
                    phase_sig_reg[2*j+1] <= shift_reg[2*j+1];
                end
            end
            if (dt_start)
                dt_cnt_reg <= dt_reg;
            else if (dt_busy & dt_tick)
                dt_cnt_reg <= dt_cnt_reg - 8'h01;
        end
    end

    // ********************************************************
    // simultaneous conduction detect
    // ********************************************************
    // both halves of one pair active at once
    assign overlap = (phase_sig_reg[0] & phase_sig_reg[1]) |
        (phase_sig_reg[2] & phase_sig_reg[3]) |
        (phase_sig_reg[4] & phase_sig_reg[5]);

    always @(posedge clk_in)
    begin
        if (sys_rst_in)
            simul_flag_reg <= 1'b0;
        else if (ctrl0_reg[`STPW_C0_SIMUL_SEL] & overlap)
            simul_flag_reg <= 1'b1;
    end

    // ********************************************************
    // pin drive and output enable
    // ********************************************************
    always @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            pwm_out <= 6'h00;
            pwm_oe_out <= 6'h3f;
        end
        else
        begin
            for (b = 0; b < 6; b = b + 1)
            begin
                // going inactive is at once, going active waits
                if (!phase_sig_reg[b])
                    pwm_out[b] <= ~ctrl1_reg[`STPW_C1_ACT_HIGH];
                else if (!dt_busy | ctrl1_reg[`STPW_C1_DT_DIS])
                    pwm_out[b] <= ctrl1_reg[`STPW_C1_ACT_HIGH];
            end
            // a detected overlap releases the pins when guarded
            pwm_oe_out <= (ctrl0_reg[`STPW_C0_OUT_EN] & ~cutoff &
                ~(ctrl0_reg[`STPW_C0_SIMUL_SEL] & simul_flag_reg)) ?
                6'h00 : 6'h3f;
        end
    end

endmodule

// ---- tb/stpw_gate_model.sv ----
// gate driver model seen at the far side of the phase outputs
`timescale 1ns/100ps
module stpw_gate_model
(
    // phase levels and active-low enables from the timer
    input wire [5:0] pwm_in,
    input wire [5:0] oe_n_in,
    // gate levels at the power stage
    output wire [5:0] gate_out
);
    // released pins fall to the pull-down level
    assign gate_out = pwm_in & ~oe_n_in;
endmodule

// ---- tb/stpw_top_properties.sv ----
// port checker for the sawtooth pwm timer
`timescale 1ns/100ps
module stpw_props
(
    // clock and reset
    input wire clk_in,
    input wire sys_rst_in,
    // block inputs
    input wire count_en_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    // block outputs
    input wire [31:0] prdata_out,
    input wire pready_out,
    input wire pslverr_out,
    input wire [5:0] pwm_out,
    input wire [5:0] pwm_oe_out,
    input wire carrier_irq_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    ready_in_access_a: assert property (pready_out |-> psel_in && penable_in)
        else $error("ready outside access");
    ready_one_cycle_a: assert property (pready_out |=> !pready_out)
        else $error("ready held too long");
    ready_first_a: assert property
        (psel_in && penable_in && !$past(penable_in) |-> pready_out)
        else $error("access not answered at once");
    err_with_ready_a: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    unmapped_read_a: assert property (pready_out && paddr_in >= 12'h040
        |-> pslverr_out && (pwrite_in || prdata_out == 32'h0))
        else $error("unmapped access not refused");
    mapped_ok_a: assert property
        (pready_out && paddr_in < 12'h040 |-> !pslverr_out)
        else $error("mapped access refused");
    irq_quiet_a: assert property (!count_en_in [*3] |=> !carrier_irq_out)
        else $error("irq without counting");
    reset_values_a: assert property ($fell(sys_rst_in) |-> pwm_oe_out ==
        6'h3f && pwm_out == 6'h00 && !carrier_irq_out && !pready_out)
        else $error("outputs not at reset values");
    oe_by_write_a: assert property (!$stable(pwm_oe_out) |->
        $past(pready_out && pwrite_in) || $past(pready_out && pwrite_in, 2))
        else $error("enable changed without write");
    irq_seen_c: cover property (carrier_irq_out);
    err_seen_c: cover property (pslverr_out);
    write_seen_c: cover property (pready_out && pwrite_in);
    pwm_seen_c: cover property (pwm_out != 6'h00);
endmodule
bind stpw_top stpw_props chk_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .count_en_in(count_en_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .pwm_out(pwm_out), .pwm_oe_out(pwm_oe_out),
    .carrier_irq_out(carrier_irq_out));

// ---- tb/tb.sv ----
// self-checking bench for the sawtooth pwm timer
`timescale 1ns/100ps
`include "stpw_regs.vh"
module tb;
    reg clk_in = 1'b0;
    reg sys_rst_in = 1'b1;
    reg count_en_in = 1'b0;
    reg psel_in = 1'b0;
    reg penable_in = 1'b0;
    reg pwrite_in = 1'b0;
    reg [11:0] paddr_in = 12'h000;
    reg [31:0] pwdata_in = 32'h0;
    wire [31:0] prdata_out;
    wire pready_out;
    wire pslverr_out;
    wire carrier_irq_out;
    wire [5:0] pwm_out;
    wire [5:0] pwm_oe_out;
    wire [5:0] gate;
    integer fails = 0;
    integer checks = 0;
    integer seed = 10521;
    integer i, k, m, n, cyc;
    reg [31:0] rd, d;
    reg err;
    reg [11:0] offs [0:4];
    reg [31:0] msk [0:4];
    always #2 clk_in = ~clk_in;
    stpw_top dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .count_en_in(count_en_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .pwm_out(pwm_out), .pwm_oe_out(pwm_oe_out),
        .carrier_irq_out(carrier_irq_out));
    stpw_gate_model gm_u (.pwm_in(pwm_out), .oe_n_in(pwm_oe_out),
        .gate_out(gate));
    function integer gap(input integer pm, input integer pn);
        gap = ((pn == 0) ? 1 : pn) * (pm + 1);
    endfunction
    task tally_and_finish;
        begin
            $display("checks %0d fails %0d", checks, fails);
            if (fails == 0 && checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp)
            begin
                fails = fails + 1;
                $display("Error at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] wd);
        integer t;
        begin
            @(posedge clk_in);
            psel_in <= 1'b1;
            pwrite_in <= w;
            paddr_in <= a;
            pwdata_in <= wd;
            @(posedge clk_in);
            penable_in <= 1'b1;
            t = 0;
            @(posedge clk_in);
            while (pready_out !== 1'b1 && t < 16)
            begin
                t = t + 1;
                @(posedge clk_in);
            end
            rd = prdata_out;
            err = pslverr_out;
            psel_in <= 1'b0;
            penable_in <= 1'b0;
            if (t == 16)
            begin
                fails = fails + 1;
                tally_and_finish;
            end
        end
    endtask
    task wait_irq;
        begin
            cyc = 1;
            @(posedge clk_in);
            while (carrier_irq_out !== 1'b1 && cyc < 5000)
            begin
                cyc = cyc + 1;
                @(posedge clk_in);
            end
            if (cyc == 5000)
            begin
                fails = fails + 1;
                tally_and_finish;
            end
        end
    endtask
    initial
    begin
        offs[0] = `STPW_LVL0_OFF;
        offs[1] = `STPW_LVL1_OFF;
        offs[2] = `STPW_PW_V_OFF;
        offs[3] = `STPW_ALT_W_OFF;
        offs[4] = `STPW_DT_OFF;
        msk[0] = 32'h3f;
        msk[1] = 32'h3f;
        msk[2] = 32'hffff;
        msk[3] = 32'hffff;
        msk[4] = 32'hff;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        apb(0, `STPW_CTRL0_OFF, 32'h0);
        chk(rd, 32'h0);
        apb(0, `STPW_IRQDIV_OFF, 32'h0);
        chk(rd, 32'h1);
        apb(0, `STPW_PW_U_OFF, 32'h0);
        chk(rd, 32'h1);
        #1;
        chk(32'(pwm_oe_out), 32'h3f);
        for (i = 0; i < 30; i = i + 1)
        begin
            d = $random(seed);
            count_en_in <= d[31];
            apb(1, offs[i % 5], d);
            apb(0, offs[i % 5], 32'h0);
            chk(rd, d & msk[i % 5]);
        end
        apb(1, 12'h040, 32'hffffffff);
        chk(32'(err), 32'h1);
        apb(0, 12'h040, 32'h0);
        chk(rd, 32'h0);
        apb(1, `STPW_CTRL0_OFF, 32'h4c);
        repeat (2) @(posedge clk_in);
        #1 chk(32'(pwm_oe_out), 32'h0);
        apb(1, `STPW_SPC_OFF, 32'h2);
        repeat (2) @(posedge clk_in);
        #1 chk(32'(pwm_oe_out), 32'h3f);
        chk(32'(gate), 32'h0);
        apb(1, `STPW_SPC_OFF, 32'h0);
        count_en_in <= 1'b1;
        for (k = 0; k < 6; k = k + 1)
        begin
            m = (k == 0) ? 0 : ($random(seed) & 7);
            n = (k == 0) ? 3 : (k == 1) ? 0 : ($random(seed) & 3) + 1;
            apb(1, `STPW_RUN_OFF, 32'h0);
            apb(1, `STPW_CTRL0_OFF, 32'h4c | (k & 3));
            apb(1, `STPW_PERIOD_OFF, m);
            apb(1, `STPW_IRQDIV_OFF, n);
            apb(1, `STPW_RUN_OFF, 32'hf);
            wait_irq;
            wait_irq;
            wait_irq;
            chk(cyc, gap(m, n));
        end
        apb(1, `STPW_RUN_OFF, 32'h0);
        apb(1, `STPW_CTRL1_OFF, 32'h30);
        apb(1, `STPW_LVL0_OFF, 32'h15);
        apb(1, `STPW_LVL1_OFF, 32'h2a);
        apb(1, `STPW_STAT_OFF, 32'h1);
        apb(1, `STPW_CTRL0_OFF, 32'hcc);
        repeat (2) @(posedge clk_in);
        #1 chk(32'(pwm_out), 32'h15);
        chk(32'(gate), 32'h15);
        apb(0, `STPW_STAT_OFF, 32'h0);
        chk(rd, 32'ha8);
        apb(1, `STPW_CTRL1_OFF, 32'h10);
        apb(1, `STPW_DT_OFF, 32'h5);
        apb(1, `STPW_LVL0_OFF, 32'h2a);
        apb(1, `STPW_CTRL0_OFF, 32'hcc);
        repeat (2) @(posedge clk_in);
        #1 chk(32'(pwm_out), 32'h0);
        repeat (6) @(posedge clk_in);
        #1 chk(32'(pwm_out), 32'h2a);
        tally_and_finish;
    end
endmodule
